// ---- core/lefr_event_flags.sv ----
`timescale 1ns/1ns
`include "lefr_map.svh"

module lefr_event_flags #(
    parameter int NUM_CH           = `LEFR_NUM_CH,
    parameter int TICK_CYCLES      = (`LEFR_CLK_HZ / 1000000) * `LEFR_TICK_US,
    parameter int SHORT_HOLD_TICKS = `LEFR_SHORT_HOLD_MS * 1000 / `LEFR_TICK_US,
    parameter int LONG_HOLD_TICKS  = `LEFR_LONG_HOLD_MS * 1000 / `LEFR_TICK_US
)(
    input  wire logic                                  core_clk,
    input  wire logic                                  reset_n,
    input  wire lefr_pkg::lefr_bus_req_type            bus_req,
    output logic [`LEFR_DATA_W-1:0]                    rd_data_r,
    input  wire lefr_pkg::lefr_line_ev_type [NUM_CH-1:0] line_ev,
    output logic                                       irq_r
);

    localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic [TICK_W-1:0]       tick_cnt_r;
    logic                    tick_r;
    logic [`LEFR_DATA_W-1:0] mask_one_r;
    logic [`LEFR_DATA_W-1:0] mask_two_r;
    logic [`LEFR_DATA_W-1:0] rd_data_nxt;
    logic                    irq_nxt;

    logic [`LEFR_DATA_W-1:0] flags_one   [NUM_CH];
    logic [`LEFR_DATA_W-1:0] flags_two   [NUM_CH];
    logic [`LEFR_DATA_W-1:0] status_one  [NUM_CH];
    logic [`LEFR_DATA_W-1:0] edge_sel    [NUM_CH];
    logic [`LEFR_DATA_W-1:0] control     [NUM_CH];
    logic [`LEFR_TALLY_W-1:0] tally      [NUM_CH];

    function automatic logic reg_hit(
        input logic [`LEFR_ADDR_W-1:0] addr,
        input logic [`LEFR_CH_W-1:0]   ch,
        input logic [`LEFR_OFS_W-1:0]  ofs
    );
        reg_hit = (addr[`LEFR_ADDR_W-1:`LEFR_CH_LSB] == ch) && (addr[`LEFR_OFS_W-1:0] == ofs);
    endfunction

    // Selects a rising edge only, or both edges when the select bit is one.
    function automatic logic edge_hit(
        input logic prev,
        input logic cur,
        input logic both_sel
    );
        edge_hit = both_sel ? (prev != cur) : (!prev && cur);
    endfunction

    function automatic logic [`LEFR_DATA_W-1:0] w1c_update(
        input logic [`LEFR_DATA_W-1:0] cur,
        input logic [`LEFR_DATA_W-1:0] set,
        input logic                    clr_en,
        input logic [`LEFR_DATA_W-1:0] clr_data,
        input logic [`LEFR_DATA_W-1:0] valid
    );
        logic [`LEFR_DATA_W-1:0] clr;
        clr        = clr_en ? clr_data : '0;
        w1c_update = ((cur & ~clr) | set) & valid;
    endfunction

    // The hold timers count in 1 ms ticks; one shared divider keeps the per-channel timers small.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mask_one_r <= `LEFR_MASK_RESET & `LEFR_FLAGS_ONE_MASK;
            mask_two_r <= `LEFR_MASK_RESET & `LEFR_FLAGS_TWO_MASK;
        end
        else if (bus_req.wr)
        begin
            if (reg_hit(bus_req.addr, `LEFR_GLOBAL_CH, `LEFR_MASK_ONE_OFS))
            begin
                mask_one_r <= bus_req.wdata & `LEFR_FLAGS_ONE_MASK;
            end
            if (reg_hit(bus_req.addr, `LEFR_GLOBAL_CH, `LEFR_MASK_TWO_OFS))
            begin
                mask_two_r <= bus_req.wdata & `LEFR_FLAGS_TWO_MASK;
            end
        end
    end

    genvar k;
    generate
        for (k = 0; k < NUM_CH; k++)
        begin : g_ch
            localparam logic [`LEFR_CH_W-1:0] CH = `LEFR_CH_W'(k);

            logic [`LEFR_DATA_W-1:0]  flags_one_r;
            logic [`LEFR_DATA_W-1:0]  flags_two_r;
            logic [`LEFR_DATA_W-1:0]  flags_one_set;
            logic [`LEFR_DATA_W-1:0]  flags_two_set;
            logic [`LEFR_DATA_W-1:0]  edge_sel_r;
            logic [`LEFR_DATA_W-1:0]  control_r;
            logic [`LEFR_DATA_W-1:0]  state_now;
            logic [`LEFR_DATA_W-1:0]  state_prev_r;
            logic [`LEFR_TALLY_W-1:0] tally_r;
            logic                     tally_wrap;
            logic                     loop_up_state;
            logic                     loop_down_state;
            logic [`LEFR_HOLD_W-1:0]  hold_ticks;

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    edge_sel_r <= `LEFR_REG_RESET;
                    control_r  <= `LEFR_REG_RESET;
                end
                else if (bus_req.wr)
                begin
                    if (reg_hit(bus_req.addr, CH, `LEFR_EDGE_SEL_OFS))
                    begin
                        edge_sel_r <= bus_req.wdata & `LEFR_EDGE_SEL_MASK;
                    end
                    if (reg_hit(bus_req.addr, CH, `LEFR_CONTROL_OFS))
                    begin
                        control_r <= bus_req.wdata & `LEFR_CONTROL_MASK;
                    end
                end
            end

            assign hold_ticks = control_r[`LEFR_AUTO_LOOP_BIT] ? `LEFR_HOLD_W'(LONG_HOLD_TICKS)
                                                                : `LEFR_HOLD_W'(SHORT_HOLD_TICKS);

            lefr_hold_timer #(
                .HOLD_W     (`LEFR_HOLD_W)
            ) u_loop_up (
                .core_clk   (core_clk),
                .reset_n    (reset_n),
                .tick       (tick_r),
                .seen       (line_ev[k].loop_up_code_seen),
                .hold_ticks (hold_ticks),
                .state_r    (loop_up_state)
            );

            lefr_hold_timer #(
                .HOLD_W     (`LEFR_HOLD_W)
            ) u_loop_down (
                .core_clk   (core_clk),
                .reset_n    (reset_n),
                .tick       (tick_r),
                .seen       (line_ev[k].loop_down_code_seen),
                .hold_ticks (hold_ticks),
                .state_r    (loop_down_state)
            );

            always_comb
            begin
                state_now                       = '0;
                state_now[`LEFR_SYS_ALARM_BIT]  = line_ev[k].sys_alarm_state;
                state_now[`LEFR_LINE_ALARM_BIT] = line_ev[k].line_alarm_state;
                state_now[`LEFR_SEQ_LOCK_BIT]   = line_ev[k].sequence_lock_state;
                state_now[`LEFR_LOOP_UP_BIT]    = loop_up_state;
                state_now[`LEFR_LOOP_DOWN_BIT]  = loop_down_state;
            end

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    state_prev_r <= `LEFR_REG_RESET;
                end
                else
                begin
                    state_prev_r <= state_now;
                end
            end

            // The tally rolls over rather than saturating so that counting carries on after the overflow flag.
            assign tally_wrap = line_ev[k].pattern_bit_error && (tally_r == '1);

            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    tally_r <= '0;
                end
                else if (line_ev[k].pattern_bit_error)
                begin
                    tally_r <= tally_r + 1'b1;
                end
            end

            always_comb
            begin
                flags_one_set = '0;
                flags_one_set[`LEFR_SYS_ALARM_BIT] = edge_hit(state_prev_r[`LEFR_SYS_ALARM_BIT],
                    state_now[`LEFR_SYS_ALARM_BIT], edge_sel_r[`LEFR_ALARM_SEL_BIT]);
                flags_one_set[`LEFR_LINE_ALARM_BIT] = edge_hit(state_prev_r[`LEFR_LINE_ALARM_BIT],
                    state_now[`LEFR_LINE_ALARM_BIT], edge_sel_r[`LEFR_ALARM_SEL_BIT]);
                flags_one_set[`LEFR_SEQ_LOCK_BIT] = edge_hit(state_prev_r[`LEFR_SEQ_LOCK_BIT],
                    state_now[`LEFR_SEQ_LOCK_BIT], edge_sel_r[`LEFR_SEQ_SEL_BIT]);
                flags_one_set[`LEFR_LOOP_UP_BIT] = edge_hit(state_prev_r[`LEFR_LOOP_UP_BIT],
                    state_now[`LEFR_LOOP_UP_BIT], edge_sel_r[`LEFR_INBAND_SEL_BIT]);
                flags_one_set[`LEFR_LOOP_DOWN_BIT] = edge_hit(state_prev_r[`LEFR_LOOP_DOWN_BIT],
                    state_now[`LEFR_LOOP_DOWN_BIT], edge_sel_r[`LEFR_INBAND_SEL_BIT]);
            end

            always_comb
            begin
                flags_two_set = '0;
                flags_two_set[`LEFR_SYS_BPV_BIT]  = line_ev[k].sys_bipolar_violation;
                flags_two_set[`LEFR_LINE_BPV_BIT] = line_ev[k].line_bipolar_violation;
                flags_two_set[`LEFR_SYS_EXZ_BIT]  = line_ev[k].sys_excess_zero;
                flags_two_set[`LEFR_LINE_EXZ_BIT] = line_ev[k].line_excess_zero;
                flags_two_set[`LEFR_PAT_ERR_BIT]  = line_ev[k].pattern_bit_error;
                flags_two_set[`LEFR_WRAP_BIT]     = tally_wrap;
            end

            // A new event in the same cycle as a clear keeps its flag set.
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    flags_one_r <= `LEFR_REG_RESET;
                    flags_two_r <= `LEFR_REG_RESET;
                end
                else
                begin
                    flags_one_r <= w1c_update(flags_one_r, flags_one_set,
                        bus_req.wr && reg_hit(bus_req.addr, CH, `LEFR_FLAGS_ONE_OFS),
                        bus_req.wdata, `LEFR_FLAGS_ONE_MASK);
                    flags_two_r <= w1c_update(flags_two_r, flags_two_set,
                        bus_req.wr && reg_hit(bus_req.addr, CH, `LEFR_FLAGS_TWO_OFS),
                        bus_req.wdata, `LEFR_FLAGS_TWO_MASK);
                end
            end

            assign flags_one[k]  = flags_one_r;
            assign flags_two[k]  = flags_two_r;
            assign status_one[k] = state_now;
            assign edge_sel[k]   = edge_sel_r;
            assign control[k]    = control_r;
            assign tally[k]      = tally_r;
        end
    endgenerate

    // Unmapped addresses and idle cycles read as zero, so the bus never sees stale data.
    always_comb
    begin
        rd_data_nxt = '0;
        if (bus_req.rd)
        begin
            if (reg_hit(bus_req.addr, `LEFR_GLOBAL_CH, `LEFR_MASK_ONE_OFS))
            begin
                rd_data_nxt = mask_one_r;
            end
            if (reg_hit(bus_req.addr, `LEFR_GLOBAL_CH, `LEFR_MASK_TWO_OFS))
            begin
                rd_data_nxt = mask_two_r;
            end
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_FLAGS_ONE_OFS))
                begin
                    rd_data_nxt = flags_one[c];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_FLAGS_TWO_OFS))
                begin
                    rd_data_nxt = flags_two[c];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_STATUS_ONE_OFS))
                begin
                    rd_data_nxt = status_one[c];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_EDGE_SEL_OFS))
                begin
                    rd_data_nxt = edge_sel[c];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_CONTROL_OFS))
                begin
                    rd_data_nxt = control[c];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_TALLY_LOW_OFS))
                begin
                    rd_data_nxt = tally[c][`LEFR_DATA_W-1:0];
                end
                if (reg_hit(bus_req.addr, `LEFR_CH_W'(c), `LEFR_TALLY_HIGH_OFS))
                begin
                    rd_data_nxt = tally[c][`LEFR_TALLY_W-1:`LEFR_DATA_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_r <= '0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
        end
    end

    always_comb
    begin
        irq_nxt = 1'b0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            irq_nxt = irq_nxt | (|(flags_one[c] & mask_one_r)) | (|(flags_two[c] & mask_two_r));
        end
    end

    // The pin follows the flags one cycle late; the mask defaults open so every flag reaches it.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irq_nxt;
        end
    end

endmodule

// ---- core/lefr_map.svh ----
`ifndef LEFR_MAP_SVH
`define LEFR_MAP_SVH

`define LEFR_NUM_CH            16
`define LEFR_ADDR_W            11
`define LEFR_DATA_W            8
`define LEFR_CH_LSB            6
`define LEFR_CH_W              5
`define LEFR_OFS_W             6

`define LEFR_FLAGS_ONE_OFS     6'h21
`define LEFR_FLAGS_TWO_OFS     6'h22
`define LEFR_TALLY_LOW_OFS     6'h23
`define LEFR_TALLY_HIGH_OFS    6'h24
`define LEFR_EDGE_SEL_OFS      6'h10
`define LEFR_STATUS_ONE_OFS    6'h11
`define LEFR_CONTROL_OFS       6'h12

`define LEFR_GLOBAL_CH         5'h1F
`define LEFR_MASK_ONE_OFS      6'h30
`define LEFR_MASK_TWO_OFS      6'h31

`define LEFR_SYS_ALARM_BIT     7
`define LEFR_LINE_ALARM_BIT    6
`define LEFR_SEQ_LOCK_BIT      5
`define LEFR_LOOP_UP_BIT       1
`define LEFR_LOOP_DOWN_BIT     0

`define LEFR_SYS_BPV_BIT       5
`define LEFR_LINE_BPV_BIT      4
`define LEFR_SYS_EXZ_BIT       3
`define LEFR_LINE_EXZ_BIT      2
`define LEFR_PAT_ERR_BIT       1
`define LEFR_WRAP_BIT          0

`define LEFR_ALARM_SEL_BIT     6
`define LEFR_SEQ_SEL_BIT       5
`define LEFR_INBAND_SEL_BIT    0
`define LEFR_AUTO_LOOP_BIT     3

`define LEFR_FLAGS_ONE_MASK    8'hE3
`define LEFR_FLAGS_TWO_MASK    8'h3F
`define LEFR_EDGE_SEL_MASK     8'h61
`define LEFR_CONTROL_MASK      8'h08
`define LEFR_REG_RESET         8'h00
`define LEFR_MASK_RESET        8'hFF

`define LEFR_TALLY_W           16
`define LEFR_CLK_HZ            10000000
`define LEFR_TICK_US           1000
`define LEFR_SHORT_HOLD_MS     40
`define LEFR_LONG_HOLD_MS      5100
`define LEFR_HOLD_W            13

`endif

// ---- core/lefr_pkg.sv ----
package lefr_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } lefr_bus_req_type;

    typedef struct packed {
        logic sys_alarm_state;
        logic line_alarm_state;
        logic sequence_lock_state;
        logic loop_up_code_seen;
        logic loop_down_code_seen;
        logic sys_bipolar_violation;
        logic line_bipolar_violation;
        logic sys_excess_zero;
        logic line_excess_zero;
        logic pattern_bit_error;
    } lefr_line_ev_type;

endpackage

// ---- core/lefr_hold_timer.sv ----
`timescale 1ns/1ns
`include "lefr_map.svh"

module lefr_hold_timer #(
    parameter int HOLD_W = `LEFR_HOLD_W
)(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              tick,
    input  wire logic              seen,
    input  wire logic [HOLD_W-1:0] hold_ticks,
    output logic                   state_r
);

    logic [HOLD_W-1:0] cnt_r;

    // The count saturates one above the hold so it cannot wrap while a code persists.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= '0;
        end
        else if (!seen)
        begin
            cnt_r <= '0;
        end
        else if (tick && (cnt_r <= hold_ticks))
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= 1'b0;
        end
        else
        begin
            state_r <= seen && (cnt_r > hold_ticks);
        end
    end

endmodule

// ---- verification/lefr_event_flags_assertions.sv ----
`timescale 1ns/1ns
`include "lefr_map.svh"
module lefr_event_flags_assertions #(
    parameter int NUM_CH = 16
)(
    input wire logic                                    core_clk,
    input wire logic                                    reset_n,
    input wire lefr_pkg::lefr_bus_req_type              bus_req,
    input wire logic [`LEFR_DATA_W-1:0]                 rd_data_r,
    input wire lefr_pkg::lefr_line_ev_type [NUM_CH-1:0] line_ev,
    input wire logic                                    irq_r
);
    logic       bpv_any;
    logic       exz_any;
    logic       err_any;
    logic       mapped;
    logic [5:0] ofs;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Event pulses of every channel feed the one interrupt pin.
    always_comb
    begin
        bpv_any = 1'b0;
        exz_any = 1'b0;
        err_any = 1'b0;
        for (int k = 0; k < NUM_CH; k++)
        begin
            bpv_any = bpv_any | line_ev[k].sys_bipolar_violation | line_ev[k].line_bipolar_violation;
            exz_any = exz_any | line_ev[k].sys_excess_zero | line_ev[k].line_excess_zero;
            err_any = err_any | line_ev[k].pattern_bit_error;
        end
    end
    assign ofs = bus_req.addr[5:0];
    assign mapped = (bus_req.addr[10:6] < NUM_CH && ofs inside {6'h10, 6'h11, 6'h12, 6'h21, 6'h22, 6'h23, 6'h24})
                    || bus_req.addr inside {11'h7F0, 11'h7F1};

    sequence s_read(o);
        bus_req.rd && ofs == o;
    endsequence
    sequence s_alarm_rise;
        $rose(line_ev[0].sys_alarm_state);
    endsequence
    sequence s_irq_late;
        ##2 irq_r;
    endsequence

    a_read_idle_zero: assert property (!bus_req.rd |=> rd_data_r == 8'h00)
        else $error("read data not zero while idle");
    a_unmapped_read_zero: assert property (bus_req.rd && !mapped |=> rd_data_r == 8'h00)
        else $error("unmapped read not zero");
    a_one_reserved_zero: assert property (s_read(6'h21) |=> rd_data_r[4:2] == 3'h0)
        else $error("reserved bits of flags one not zero");
    a_two_reserved_zero: assert property (s_read(6'h22) |=> rd_data_r[7:6] == 2'h0)
        else $error("reserved bits of flags two not zero");
    a_bpv_raises_irq: assert property (bpv_any |-> s_irq_late)
        else $error("violation event did not raise interrupt");
    a_exz_raises_irq: assert property (exz_any |-> s_irq_late)
        else $error("excess zero event did not raise interrupt");
    a_err_raises_irq: assert property (err_any |-> s_irq_late)
        else $error("pattern error event did not raise interrupt");
    a_alarm_rise_irq: assert property (s_alarm_rise |-> s_irq_late)
        else $error("alarm rise did not raise interrupt");
    a_irq_stays_high: assert property (irq_r && !bus_req.wr && !$past(bus_req.wr) |=> irq_r)
        else $error("interrupt dropped without a write");
    a_reset_outputs_low: assert property ($rose(reset_n) |-> !irq_r && rd_data_r == 8'h00)
        else $error("outputs not low after reset");
endmodule

bind lefr_event_flags lefr_event_flags_assertions #(.NUM_CH(NUM_CH)) u_chk (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bus_req  (bus_req),
    .rd_data_r(rd_data_r),
    .line_ev  (line_ev),
    .irq_r    (irq_r)
);

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`include "lefr_map.svh"
module tb;
    localparam int NCH = 2;
    logic                                 core_clk;
    logic                                 reset_n;
    lefr_pkg::lefr_bus_req_type           bus_req;
    logic [7:0]                           rd_data_r;
    lefr_pkg::lefr_line_ev_type [NCH-1:0] line_ev;
    logic                                 irq_r;
    int                                   err_count;
    int                                   checks;
    logic [5:0]                           ofs_tab [7] = '{6'h10, 6'h11, 6'h12, 6'h21, 6'h22, 6'h23, 6'h24};
    logic [7:0]                           bit_tab [5] = '{8'h80, 8'h40, 8'h20, 8'h02, 8'h01};

    // Short tick and hold counts keep the loop code timers within a few dozen cycles.
    lefr_event_flags #(.NUM_CH(NCH), .TICK_CYCLES(4), .SHORT_HOLD_TICKS(3), .LONG_HOLD_TICKS(6)) u_dut (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .bus_req  (bus_req),
        .rd_data_r(rd_data_r),
        .line_ev  (line_ev),
        .irq_r    (irq_r)
    );

    always #50 core_clk = ~core_clk;

    function automatic logic [10:0] ad(input logic [4:0] c, input logic [5:0] o);
        return {c, o};
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data are valid only in the cycle after the strobe, so they are taken mid-cycle there.
    task automatic rd(input logic [10:0] a, input logic [7:0] e, input string name);
        @(posedge core_clk);
        bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        chk(name, rd_data_r, e);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        report_and_stop;
    end

    initial
    begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        bus_req = '0;
        line_ev = '0;
        err_count = 0;
        checks = 0;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(ad(5'h00, ofs_tab[i]), 8'h00, "reset value");
        rd(11'h7F0, `LEFR_FLAGS_ONE_MASK, "mask one reset");
        rd(11'h7F1, `LEFR_FLAGS_TWO_MASK, "mask two reset");
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            line_ev[1][4-i] <= 1'b1;
            @(posedge core_clk);
            line_ev[1][4-i] <= 1'b0;
            rd(ad(5'h01, 6'h22), 8'h20 >> i, "flags two set");
            rd(ad(5'h00, 6'h22), 8'h00, "other channel");
            chk("irq set", {7'h00, irq_r}, 8'h01);
            wr(ad(5'h01, 6'h22), 8'h00);
            rd(ad(5'h01, 6'h22), 8'h20 >> i, "zero write");
            wr(ad(5'h01, 6'h22), 8'h20 >> i);
            rd(ad(5'h01, 6'h22), 8'h00, "write one clear");
            chk("irq clear", {7'h00, irq_r}, 8'h00);
        end
        for (int s = 0; s < 5; s++)
            for (int sel = 0; sel < 2; sel++)
            begin
                wr(ad(5'h00, 6'h10), sel ? 8'h61 : 8'h00);
                @(posedge core_clk);
                line_ev[0][9-s] <= 1'b1;
                repeat (40) @(posedge core_clk);
                rd(ad(5'h00, 6'h11), bit_tab[s], "status");
                rd(ad(5'h00, 6'h21), bit_tab[s], "rise");
                wr(ad(5'h00, 6'h21), bit_tab[s]);
                line_ev[0][9-s] <= 1'b0;
                repeat (40) @(posedge core_clk);
                rd(ad(5'h00, 6'h21), sel ? bit_tab[s] : 8'h00, "fall");
                wr(ad(5'h00, 6'h21), bit_tab[s]);
            end
        wr(11'h7F0, 8'hE2);
        @(posedge core_clk);
        line_ev[0].loop_down_code_seen <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd(ad(5'h00, 6'h21), 8'h01, "masked flag");
        chk("irq masked", {7'h00, irq_r}, 8'h00);
        wr(11'h7F0, 8'hE3);
        rd(11'h7F0, 8'hE3, "mask readback");
        chk("irq unmasked", {7'h00, irq_r}, 8'h01);
        // Inputs only move just after a rising edge, never at the mid-cycle sampling point of a read.
        @(posedge core_clk);
        line_ev[0].loop_down_code_seen <= 1'b0;
        wr(ad(5'h00, 6'h12), 8'h08);
        @(posedge core_clk);
        line_ev[0].loop_up_code_seen <= 1'b1;
        repeat (22) @(posedge core_clk);
        rd(ad(5'h00, 6'h11), 8'h00, "long hold early");
        repeat (14) @(posedge core_clk);
        rd(ad(5'h00, 6'h11), 8'h02, "long hold done");
        @(posedge core_clk);
        line_ev[0].loop_up_code_seen <= 1'b0;
        repeat (10) @(posedge core_clk);
        wr(ad(5'h00, 6'h21), 8'hFF);
        // Each cycle with the error input high counts one, so a held level walks the tally to its top.
        @(posedge core_clk);
        line_ev[0].pattern_bit_error <= 1'b1;
        repeat (65535) @(posedge core_clk);
        line_ev[0].pattern_bit_error <= 1'b0;
        rd(ad(5'h00, 6'h23), 8'hFF, "tally low full");
        rd(ad(5'h00, 6'h24), 8'hFF, "tally high full");
        rd(ad(5'h00, 6'h22), 8'h02, "no wrap yet");
        @(posedge core_clk);
        line_ev[0].pattern_bit_error <= 1'b1;
        @(posedge core_clk);
        line_ev[0].pattern_bit_error <= 1'b0;
        rd(ad(5'h00, 6'h22), 8'h03, "wrap flag");
        rd(ad(5'h00, 6'h23), 8'h00, "tally low wrapped");
        rd(ad(5'h00, 6'h24), 8'h00, "tally high wrapped");
        wr(ad(5'h00, 6'h22), 8'hFF);
        rd(ad(5'h00, 6'h22), 8'h00, "flags two cleared");
        wr(ad(5'h00, 6'h11), 8'hFF);
        rd(ad(5'h00, 6'h11), 8'h00, "status read only");
        wr(ad(5'h00, 6'h23), 8'hFF);
        rd(ad(5'h00, 6'h23), 8'h00, "tally read only");
        wr(ad(5'h00, 6'h05), 8'hFF);
        rd(ad(5'h00, 6'h05), 8'h00, "unmapped");
        rd(ad(5'h05, 6'h21), 8'h00, "absent channel");
        wr(ad(5'h00, 6'h10), 8'hFF);
        rd(ad(5'h00, 6'h10), `LEFR_EDGE_SEL_MASK, "edge select bits");
        wr(ad(5'h00, 6'h12), 8'hFF);
        rd(ad(5'h00, 6'h12), `LEFR_CONTROL_MASK, "control bits");
        @(posedge core_clk);
        line_ev[1].sys_excess_zero <= 1'b1;
        @(posedge core_clk);
        line_ev[1].sys_excess_zero <= 1'b0;
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(ad(5'h01, 6'h22), 8'h00, "flag after reset");
        rd(ad(5'h00, 6'h10), 8'h00, "select after reset");
        chk("irq after reset", {7'h00, irq_r}, 8'h00);
        report_and_stop;
    end
endmodule
